// ===== design/alu_pkg.sv
// Shared types and constants of the integer arithmetic and flag unit
package alu_pkg;

  // Bit positions inside the flag word
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_HALF_CARRY = 4;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_OVERFLOW = 11;

  localparam logic [15:0] FLAG_WORD_RESET = 16'h0000;
  // Sign, zero, half carry, parity and carry in the high byte image
  localparam logic [7:0] HIGH_BYTE_FLAG_MASK = 8'hd5;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [7:0] DIVIDE_FAULT_TYPE = 8'h00;
  localparam logic [7:0] SINGLE_COUNT = 8'h01;
  localparam int MAX_SHIFT_STEPS = 255;

  typedef enum logic [4:0] {
    add_op, carry_add_op, plus_one_op, subtract_op, difference_with_borrow_op,
    minus_one_op, twos_complement_op, compare_op, unsigned_product_op,
    signed_product_op, unsigned_quotient_op, signed_quotient_op,
    byte_to_word_extend_op, word_to_double_extend_op, ones_complement_op,
    logical_left_op, logical_right_op, arithmetic_left_op, arithmetic_right_op,
    circular_left_op, circular_right_op, carry_circular_left_op,
    carry_circular_right_op, conjunction_op, disjunction_op, exclusive_op,
    test_op, flags_to_high_byte_op, high_byte_to_flags_op, flag_push_op,
    flag_pop_op
  } alu_op_t;

  typedef struct packed {
    alu_op_t op;
    logic word_mode;
    logic by_count;
    logic [15:0] dest;
    logic [15:0] src;
    logic [15:0] accumulator_word;
    logic [15:0] accumulator_extension_word;
    logic [7:0] count_register_low;
    logic [15:0] stack_pointer;
    logic [15:0] stack_read_data;
  } alu_req_t;

endpackage : alu_pkg

// ===== design/result_flags.sv
// Sign, zero and parity of a byte or word result
`timescale 1ns/1ps
module result_flags (
  // Value
  input wire logic [15:0] value,
  input wire logic word_mode,
  // Flags
  output logic sign,
  output logic zero,
  output logic parity
);
  assign sign = word_mode ? value[15] : value[7];
  assign zero = word_mode ? (value == 16'h0000) : (value[7:0] == 8'h00);
  assign parity = ~^value[7:0];
endmodule : result_flags

// ===== design/integer_alu_flag_unit.sv
// Integer arithmetic, logic and flag datapath
// Behaviour
// - Carry flag is carry out of or borrow into the top result bit.
// - Half carry flag is carry out of or borrow into the low nibble.
// - Sign flag copies the top bit of the result.
// - Parity flag set when the low result byte has even parity.
// - Overflow flag is carry into top bit xor carry out of it.
// - Flags-to-high-byte copies the whole low flag byte, the five flags included, into the accumulator high byte.
// - High-byte-to-flags loads those five flags, others unchanged.
// - Flag push lowers stack pointer by two, then writes the flag word.
// - Flag pop loads all flags from stack, then raises pointer by two.
// - Carry add adds carry flag; borrow subtract subtracts carry flag.
// - Decrement, increment, negate write the result back to the operand.
// - Compare subtracts and sets flags but writes no result.
// - Unsigned product double width; carry, overflow when upper half nonzero.
// - Signed product: carry, overflow when upper half is not sign extension.
// - Divide accumulator pair (byte mode: accumulator); quotient low, remainder extension or, in byte mode, accumulator high byte; flags kept.
// - Zero divisor raises fault of type 0 instead of dividing.
// - Byte-to-word and word-to-double replicate the accumulator sign.
// - Ones complement inverts operand, flags unchanged.
// - Shifts: carry is last bit out, parity sign zero set, overflow on count 1.
// - Rotates: carry is last bit out, overflow on count 1 as sign change.
// - Logic ops clear carry and overflow, set sign parity zero; test no write.
`timescale 1ns/1ps
module integer_alu_flag_unit
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Request
  input wire logic op_valid,
  input wire alu_req_t req,
  // Results
  output logic done,
  output logic [15:0] result,
  output logic result_write,
  output logic [15:0] accumulator_out,
  output logic accumulator_write,
  output logic [15:0] extension_out,
  output logic extension_write,
  // Stack
  output logic [15:0] stack_pointer_out,
  output logic stack_pointer_write,
  output logic stack_write,
  output logic [15:0] stack_write_data,
  // Flags and fault
  output logic [15:0] flag_word,
  output logic divide_fault,
  output logic [7:0] fault_type
);
  logic [15:0] mask, top_bit;
  logic [15:0] arith_x, arith_y, x_eff, y_eff, carry_bits, arith_result;
  logic arith_cin, arith_sub, carry_out, arith_carry, arith_half, arith_over;
  logic [16:0] arith_sum;
  logic [31:0] product_u, product_s, product;
  logic signed [15:0] prod_sb;
  logic signed [31:0] prod_sw;
  logic product_wide;
  logic is_signed, neg_dd, neg_dv, quo_fault;
  logic [31:0] dd_ext, num, quo_mag, rem_mag, quo, rem, limit;
  logic [15:0] dv_ext, den, den_safe;
  logic [7:0] shift_count;
  logic [15:0] sh_v, logic_value, flag_value;
  logic sh_c, sh_n, sh_over;
  logic val_sign, val_zero, val_parity;
  logic [15:0] next_result, next_acc, next_ext, next_sp, next_flags;
  logic next_result_write, next_acc_write, next_ext_write, next_sp_write;
  logic next_stack_write, next_fault;

  assign mask = req.word_mode ? 16'hffff : 16'h00ff;
  assign top_bit = req.word_mode ? 16'h8000 : 16'h0080;

  // Adder operand selection
  always_comb begin
    arith_x = req.dest;
    arith_y = req.src;
    arith_cin = 1'b0;
    arith_sub = 1'b0;
    case (req.op)
      carry_add_op: arith_cin = flag_word[FLAG_CARRY];
      plus_one_op: arith_y = 16'h0001;
      subtract_op, compare_op: arith_sub = 1'b1;
      difference_with_borrow_op: begin
        arith_sub = 1'b1;
        arith_cin = flag_word[FLAG_CARRY];
      end
      minus_one_op: begin
        arith_sub = 1'b1;
        arith_y = 16'h0001;
      end
      twos_complement_op: begin
        arith_sub = 1'b1;
        arith_x = 16'h0000;
        arith_y = req.dest;
      end
      default: ;
    endcase
  end

  assign x_eff = arith_x & mask;
  assign y_eff = (arith_sub ? ~arith_y : arith_y) & mask;
  assign arith_sum = {1'b0, x_eff} + {1'b0, y_eff} + {16'h0000, arith_sub ^ arith_cin};
  assign carry_bits = x_eff ^ y_eff ^ arith_sum[15:0];
  assign carry_out = req.word_mode ? arith_sum[16] : arith_sum[8];
  assign arith_result = arith_sum[15:0] & mask;
  assign arith_carry = carry_out ^ arith_sub;
  assign arith_half = carry_bits[4] ^ arith_sub;
  assign arith_over = (|(carry_bits & top_bit)) ^ carry_out;

  // Multiplier
  assign product_u = {16'h0000, req.accumulator_word & mask} * {16'h0000, req.src & mask};
  assign prod_sb = $signed({{8{req.accumulator_word[7]}}, req.accumulator_word[7:0]}) *
                   $signed({{8{req.src[7]}}, req.src[7:0]});
  assign prod_sw = $signed({{16{req.accumulator_word[15]}}, req.accumulator_word}) *
                   $signed({{16{req.src[15]}}, req.src});
  assign product_s = req.word_mode ? prod_sw : {{16{prod_sb[15]}}, prod_sb};
  assign product = (req.op == signed_product_op) ? product_s : product_u;
  always_comb begin
    if (req.op == signed_product_op) begin
      product_wide = req.word_mode ? (product[31:16] != {16{product[15]}})
                                   : (product[15:8] != {8{product[7]}});
    end else begin
      product_wide = req.word_mode ? (|product[31:16]) : (|product[15:8]);
    end
  end

  // Divider on magnitudes
  assign is_signed = (req.op == signed_quotient_op);
  assign dd_ext = req.word_mode ? {req.accumulator_extension_word, req.accumulator_word}
                : is_signed ? {{16{req.accumulator_word[15]}}, req.accumulator_word}
                : {16'h0000, req.accumulator_word};
  assign dv_ext = req.word_mode ? req.src
                : is_signed ? {{8{req.src[7]}}, req.src[7:0]} : {8'h00, req.src[7:0]};
  assign neg_dd = is_signed & dd_ext[31];
  assign neg_dv = is_signed & dv_ext[15];
  assign num = neg_dd ? 32'h00000000 - dd_ext : dd_ext;
  assign den = neg_dv ? 16'h0000 - dv_ext : dv_ext;
  assign den_safe = (den == 16'h0000) ? 16'h0001 : den;
  assign quo_mag = num / {16'h0000, den_safe};
  assign rem_mag = num % {16'h0000, den_safe};
  assign quo = (neg_dd ^ neg_dv) ? 32'h00000000 - quo_mag : quo_mag;
  assign rem = neg_dd ? 32'h00000000 - rem_mag : rem_mag;
  assign limit = !is_signed ? {16'h0000, mask}
               : (neg_dd ^ neg_dv) ? {16'h0000, top_bit} : {16'h0000, top_bit - 16'h0001};
  assign quo_fault = (den == 16'h0000) || (quo_mag > limit);

  // Shifter and rotator, one step per count
  assign shift_count = req.by_count ? req.count_register_low : SINGLE_COUNT;
  always_comb begin
    sh_v = req.dest & mask;
    sh_c = flag_word[FLAG_CARRY];
    sh_n = 1'b0;
    for (int i = 0; i < MAX_SHIFT_STEPS; i++) begin
      if (8'(i) < shift_count) begin
        case (req.op)
          logical_left_op, arithmetic_left_op: begin
            sh_c = |(sh_v & top_bit);
            sh_v = (sh_v << 1) & mask;
          end
          logical_right_op: begin
            sh_c = sh_v[0];
            sh_v = sh_v >> 1;
          end
          arithmetic_right_op: begin
            sh_c = sh_v[0];
            sh_v = (sh_v >> 1) | (sh_v & top_bit);
          end
          circular_left_op: begin
            sh_c = |(sh_v & top_bit);
            sh_v = ((sh_v << 1) & mask) | {15'h0000, sh_c};
          end
          circular_right_op: begin
            sh_c = sh_v[0];
            sh_v = (sh_v >> 1) | (sh_c ? top_bit : 16'h0000);
          end
          carry_circular_left_op: begin
            sh_n = |(sh_v & top_bit);
            sh_v = ((sh_v << 1) & mask) | {15'h0000, sh_c};
            sh_c = sh_n;
          end
          carry_circular_right_op: begin
            sh_n = sh_v[0];
            sh_v = (sh_v >> 1) | (sh_c ? top_bit : 16'h0000);
            sh_c = sh_n;
          end
          default: ;
        endcase
      end
    end
  end
  assign sh_over = |((sh_v ^ req.dest) & top_bit);

  // Bitwise logic
  always_comb begin
    case (req.op)
      disjunction_op: logic_value = (req.dest | req.src) & mask;
      exclusive_op: logic_value = (req.dest ^ req.src) & mask;
      default: logic_value = req.dest & req.src & mask;
    endcase
  end

  always_comb begin
    case (req.op)
      conjunction_op, disjunction_op, exclusive_op, test_op: flag_value = logic_value;
      logical_left_op, logical_right_op, arithmetic_left_op, arithmetic_right_op:
        flag_value = sh_v;
      default: flag_value = arith_result;
    endcase
  end

  result_flags result_flags_i (
    .value(flag_value),
    .word_mode(req.word_mode),
    .sign(val_sign),
    .zero(val_zero),
    .parity(val_parity)
  );

  // Next values for every operation
  always_comb begin
    next_result = result;
    next_acc = accumulator_out;
    next_ext = extension_out;
    next_sp = stack_pointer_out;
    next_flags = flag_word;
    next_result_write = 1'b0;
    next_acc_write = 1'b0;
    next_ext_write = 1'b0;
    next_sp_write = 1'b0;
    next_stack_write = 1'b0;
    next_fault = 1'b0;
    case (req.op)
      add_op, carry_add_op, plus_one_op, subtract_op, difference_with_borrow_op,
      minus_one_op, twos_complement_op, compare_op: begin
        next_result = arith_result;
        next_result_write = (req.op != compare_op);
        if (req.op != plus_one_op && req.op != minus_one_op) begin
          next_flags[FLAG_CARRY] = arith_carry;
        end
        next_flags[FLAG_HALF_CARRY] = arith_half;
        next_flags[FLAG_OVERFLOW] = arith_over;
        next_flags[FLAG_ZERO] = val_zero;
        next_flags[FLAG_SIGN] = val_sign;
        next_flags[FLAG_PARITY] = val_parity;
      end
      unsigned_product_op, signed_product_op: begin
        next_acc = req.word_mode ? product[15:0] : product[15:0] & 16'hffff;
        next_ext = product[31:16];
        next_acc_write = 1'b1;
        next_ext_write = req.word_mode;
        next_flags[FLAG_CARRY] = product_wide;
        next_flags[FLAG_OVERFLOW] = product_wide;
      end
      unsigned_quotient_op, signed_quotient_op: begin
        if (quo_fault) begin
          next_fault = 1'b1;
        end else if (req.word_mode) begin
          next_acc = quo[15:0];
          next_ext = rem[15:0];
          next_acc_write = 1'b1;
          next_ext_write = 1'b1;
        end else begin
          next_acc = {rem[7:0], quo[7:0]};
          next_acc_write = 1'b1;
        end
      end
      byte_to_word_extend_op: begin
        next_acc = {{8{req.accumulator_word[7]}}, req.accumulator_word[7:0]};
        next_acc_write = 1'b1;
      end
      word_to_double_extend_op: begin
        next_ext = {16{req.accumulator_word[15]}};
        next_ext_write = 1'b1;
      end
      ones_complement_op: begin
        next_result = ~req.dest & mask;
        next_result_write = 1'b1;
      end
      logical_left_op, logical_right_op, arithmetic_left_op, arithmetic_right_op,
      circular_left_op, circular_right_op, carry_circular_left_op,
      carry_circular_right_op: begin
        next_result = sh_v;
        next_result_write = 1'b1;
        if (shift_count != 8'h00) begin
          next_flags[FLAG_CARRY] = sh_c;
          if (shift_count == SINGLE_COUNT) begin
            next_flags[FLAG_OVERFLOW] = sh_over;
          end
          if (req.op == logical_left_op || req.op == logical_right_op ||
              req.op == arithmetic_left_op || req.op == arithmetic_right_op) begin
            next_flags[FLAG_ZERO] = val_zero;
            next_flags[FLAG_SIGN] = val_sign;
            next_flags[FLAG_PARITY] = val_parity;
          end
        end
      end
      conjunction_op, disjunction_op, exclusive_op, test_op: begin
        next_result = logic_value;
        next_result_write = (req.op != test_op);
        next_flags[FLAG_CARRY] = 1'b0;
        next_flags[FLAG_OVERFLOW] = 1'b0;
        next_flags[FLAG_ZERO] = val_zero;
        next_flags[FLAG_SIGN] = val_sign;
        next_flags[FLAG_PARITY] = val_parity;
      end
      flags_to_high_byte_op: begin
        next_acc = {flag_word[7:0], req.accumulator_word[7:0]};
        next_acc_write = 1'b1;
      end
      high_byte_to_flags_op: begin
        next_flags[7:0] = (flag_word[7:0] & ~HIGH_BYTE_FLAG_MASK) |
                          (req.accumulator_word[15:8] & HIGH_BYTE_FLAG_MASK);
      end
      flag_push_op: begin
        next_sp = req.stack_pointer - STACK_STEP;
        next_sp_write = 1'b1;
        next_stack_write = 1'b1;
      end
      flag_pop_op: begin
        next_flags = req.stack_read_data;
        next_sp = req.stack_pointer + STACK_STEP;
        next_sp_write = 1'b1;
      end
      default: ;
    endcase
  end

  // Flag word
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag_word <= FLAG_WORD_RESET;
    end else if (op_valid) begin
      flag_word <= next_flags;
    end
  end

  // Operand and accumulator results
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      result <= 16'h0000;
      result_write <= 1'b0;
      accumulator_out <= 16'h0000;
      accumulator_write <= 1'b0;
      extension_out <= 16'h0000;
      extension_write <= 1'b0;
    end else begin
      result_write <= op_valid & next_result_write;
      accumulator_write <= op_valid & next_acc_write;
      extension_write <= op_valid & next_ext_write;
      if (op_valid) begin
        result <= next_result;
        accumulator_out <= next_acc;
        extension_out <= next_ext;
      end
    end
  end

  // Stack traffic
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stack_pointer_out <= 16'h0000;
      stack_pointer_write <= 1'b0;
      stack_write <= 1'b0;
      stack_write_data <= 16'h0000;
    end else begin
      stack_pointer_write <= op_valid & next_sp_write;
      stack_write <= op_valid & next_stack_write;
      if (op_valid) begin
        stack_pointer_out <= next_sp;
        stack_write_data <= flag_word;
      end
    end
  end

  // Completion and divide fault
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      done <= 1'b0;
      divide_fault <= 1'b0;
      fault_type <= 8'h00;
    end else begin
      done <= op_valid;
      divide_fault <= op_valid & next_fault;
      if (op_valid & next_fault) begin
        fault_type <= DIVIDE_FAULT_TYPE;
      end
    end
  end

  carry_add_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == add_op && req.word_mode &&
    ({1'b0, req.dest} + {1'b0, req.src}) > 17'h0ffff |=> flag_word[FLAG_CARRY])
    else $error("carry not set on word add overflow");
  half_borrow_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == subtract_op |=>
    flag_word[FLAG_HALF_CARRY] == ($past(req.dest[3:0]) < $past(req.src[3:0])))
    else $error("half carry wrong on subtract");
  zero_equal_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == subtract_op && req.dest == req.src |=>
    flag_word[FLAG_ZERO] && result == 16'h0000 && result_write)
    else $error("zero flag not set on equal subtract");
  sign_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == disjunction_op && req.word_mode |=>
    flag_word[FLAG_SIGN] == result[15])
    else $error("sign flag differs from result top bit");
  parity_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == exclusive_op |=> flag_word[FLAG_PARITY] == ~^result[7:0])
    else $error("parity flag wrong");
  signed_over_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == add_op && req.word_mode && req.dest == 16'h7fff &&
    req.src == 16'h0001 |=> flag_word[FLAG_OVERFLOW] && !flag_word[FLAG_CARRY])
    else $error("overflow not set on positive wrap");
  high_byte_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == flags_to_high_byte_op |=>
    accumulator_write && accumulator_out[15:8] == $past(flag_word[7:0]))
    else $error("flag image not in high byte");
  push_order_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == flag_push_op |=> stack_write && stack_pointer_write &&
    stack_pointer_out == $past(req.stack_pointer) - STACK_STEP &&
    stack_write_data == $past(flag_word))
    else $error("flag push wrong");
  pop_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == flag_pop_op |=> flag_word == $past(req.stack_read_data) &&
    stack_pointer_out == $past(req.stack_pointer) + STACK_STEP && !stack_write)
    else $error("flag pop wrong");
  compare_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == compare_op |=> done && !result_write)
    else $error("compare wrote a result");
  zero_divisor_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == unsigned_quotient_op && req.src == 16'h0000 |=>
    divide_fault && fault_type == DIVIDE_FAULT_TYPE && !accumulator_write)
    else $error("zero divisor did not fault");
  complement_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == ones_complement_op && req.word_mode |=>
    flag_word == $past(flag_word) && result == ~$past(req.dest))
    else $error("complement wrong or flags touched");
  logic_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid && req.op == test_op |=> !flag_word[FLAG_CARRY] &&
    !flag_word[FLAG_OVERFLOW] && !result_write)
    else $error("test op wrote result or kept carry");

endmodule : integer_alu_flag_unit

// ===== tb/stack_word_model.sv
// Stack word store that serves the flag push and pop operations
`timescale 1ns/1ps
module stack_word_model (
  // Clock
  input wire logic clock,
  // Write side
  input wire logic write,
  input wire logic [15:0] address,
  input wire logic [15:0] write_data,
  // Read side
  input wire logic [15:0] read_address,
  output logic [15:0] read_data
);
  logic [15:0] words [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      words[i] = 16'ha5a5;
    end
  end
  always @(posedge clock) begin
    if (write) begin
      words[address[4:1]] <= write_data;
    end
  end
  assign read_data = words[read_address[4:1]];
endmodule : stack_word_model

// ===== tb/testbench.sv
// Self-checking bench of the integer arithmetic and flag unit
`timescale 1ns/1ps
module testbench;
  import alu_pkg::*;
  typedef struct packed {
    alu_op_t op;
    logic [3:0] k;
    logic [7:0] c;
    logic [15:0] d;
    logic [15:0] s;
    logic [15:0] e;
    logic [15:0] f;
    logic [15:0] m;
  } row_t;
  localparam int N = 31;
  // Word mode, output select and write pulse packed in k
  localparam row_t ROWS [N] = '{
    '{add_op, 4'h1, 8'h01, 16'h00ff, 16'h0001, 16'h0000, 16'h0055, 16'h08d5},
    '{difference_with_borrow_op, 4'h1, 8'h01, 16'h0005, 16'h0003, 16'h0001, 16'h0000, 16'h08d5},
    '{subtract_op, 4'h1, 8'h01, 16'h0000, 16'h0001, 16'h00ff, 16'h0095, 16'h08d5},
    '{carry_add_op, 4'h1, 8'h01, 16'h0010, 16'h0010, 16'h0021, 16'h0004, 16'h08d5},
    '{add_op, 4'h9, 8'h01, 16'h8000, 16'h8000, 16'h0000, 16'h0845, 16'h08d5},
    '{minus_one_op, 4'h1, 8'h01, 16'h0001, 16'h0001, 16'h0000, 16'h0044, 16'h08d4},
    '{plus_one_op, 4'h1, 8'h01, 16'h007f, 16'h007f, 16'h0080, 16'h0890, 16'h08d4},
    '{twos_complement_op, 4'h1, 8'h01, 16'h0001, 16'h0001, 16'h00ff, 16'h0095, 16'h08d5},
    '{conjunction_op, 4'h1, 8'h01, 16'h00f0, 16'h003c, 16'h0030, 16'h0004, 16'h08c5},
    '{compare_op, 4'h0, 8'h01, 16'h0005, 16'h0005, 16'h0000, 16'h0044, 16'h08d5},
    '{disjunction_op, 4'h9, 8'h01, 16'h8000, 16'h0001, 16'h8001, 16'h0080, 16'h08c5},
    '{exclusive_op, 4'h9, 8'h01, 16'hffff, 16'h00ff, 16'hff00, 16'h0084, 16'h08c5},
    '{test_op, 4'h0, 8'h01, 16'h00ff, 16'h0000, 16'h0000, 16'h0044, 16'h08c5},
    '{ones_complement_op, 4'h9, 8'h01, 16'h000f, 16'h0000, 16'hfff0, 16'h0044, 16'h08c5},
    '{logical_left_op, 4'h1, 8'h01, 16'h0081, 16'h0000, 16'h0002, 16'h0801, 16'h08c5},
    '{logical_right_op, 4'h1, 8'h02, 16'h0081, 16'h0000, 16'h0020, 16'h0000, 16'h00c5},
    '{arithmetic_right_op, 4'h1, 8'h03, 16'h0080, 16'h0000, 16'h00f0, 16'h0084, 16'h00c5},
    '{arithmetic_left_op, 4'h1, 8'h01, 16'h0040, 16'h0000, 16'h0080, 16'h0880, 16'h08c5},
    '{circular_left_op, 4'h1, 8'h04, 16'h0081, 16'h0000, 16'h0018, 16'h0000, 16'h0001},
    '{circular_right_op, 4'h1, 8'h01, 16'h0001, 16'h0000, 16'h0080, 16'h0801, 16'h0801},
    '{carry_circular_left_op, 4'h1, 8'h01, 16'h0080, 16'h0000, 16'h0001, 16'h0801, 16'h0801},
    '{carry_circular_right_op, 4'h1, 8'h01, 16'h0000, 16'h0000, 16'h0080, 16'h0800, 16'h0801},
    '{unsigned_product_op, 4'h3, 8'h01, 16'h0010, 16'h0010, 16'h0100, 16'h0801, 16'h0801},
    '{signed_product_op, 4'h3, 8'h01, 16'h00ff, 16'h0002, 16'hfffe, 16'h0000, 16'h0801},
    '{unsigned_product_op, 4'hd, 8'h01, 16'h1000, 16'h0010, 16'h0001, 16'h0801, 16'h0801},
    '{unsigned_quotient_op, 4'h3, 8'h01, 16'h0007, 16'h0002, 16'h0103, 16'h0000, 16'h0000},
    '{signed_quotient_op, 4'h3, 8'h01, 16'hfff9, 16'h0002, 16'hfffd, 16'h0000, 16'h0000},
    '{byte_to_word_extend_op, 4'h3, 8'h01, 16'h0080, 16'h0000, 16'hff80, 16'h0000, 16'h0000},
    '{word_to_double_extend_op, 4'hd, 8'h01, 16'h8000, 16'h0000, 16'hffff, 16'h0000, 16'h0000},
    '{add_op, 4'h9, 8'h01, 16'h7fff, 16'h0001, 16'h8000, 16'h0894, 16'h08d5},
    '{subtract_op, 4'h1, 8'h01, 16'h0033, 16'h0033, 16'h0000, 16'h0044, 16'h08d5}
  };
  logic clock, reset_n, op_valid;
  alu_req_t drive, req;
  logic done, result_write, accumulator_write, extension_write;
  logic stack_pointer_write, stack_write, divide_fault;
  logic [15:0] result, accumulator_out, extension_out, stack_pointer_out;
  logic [15:0] stack_write_data, flag_word, stack_word, keep;
  logic [7:0] fault_type;
  int miscompares, n_compared;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always_comb begin
    req = drive;
    req.stack_read_data = stack_word;
  end
  integer_alu_flag_unit integer_alu_flag_unit_inst (.clock(clock), .reset_n(reset_n),
    .op_valid(op_valid), .req(req), .done(done), .result(result),
    .result_write(result_write), .accumulator_out(accumulator_out),
    .accumulator_write(accumulator_write), .extension_out(extension_out),
    .extension_write(extension_write), .stack_pointer_out(stack_pointer_out),
    .stack_pointer_write(stack_pointer_write), .stack_write(stack_write),
    .stack_write_data(stack_write_data), .flag_word(flag_word),
    .divide_fault(divide_fault), .fault_type(fault_type));
  stack_word_model stack_word_model_inst (.clock(clock), .write(stack_write),
    .address(stack_pointer_out), .write_data(stack_write_data),
    .read_address(drive.stack_pointer), .read_data(stack_word));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input alu_op_t op, input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [15:0] s, input logic [15:0] x,
                     input logic [15:0] sp);
    drive = '{op, w, c != 8'h01, d, s, d, x, c, sp, 16'h0000};
    op_valid = 1'b1;
  endtask : put
  task automatic op1(input alu_op_t op, input logic w, input logic [15:0] d,
                     input logic [15:0] s, input logic [15:0] x, input logic [15:0] sp);
    @(negedge clock);
    put(op, w, 8'h01, d, s, x, sp);
    @(negedge clock);
    op_valid = 1'b0;
  endtask : op1
  function automatic logic [16:0] pick(input logic [1:0] sel);
    case (sel)
      2'h1: pick = {accumulator_write, accumulator_out};
      2'h2: pick = {extension_write, extension_out};
      default: pick = {result_write, result};
    endcase
  endfunction : pick
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    row_t r;
    logic [16:0] v;
    op_valid = 1'b0;
    drive = '0;
    reset_n = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (3) @(negedge clock);
    chk(flag_word, FLAG_WORD_RESET);
    reset_n = 1'b1;
    $display("reset test done");
    // Back-to-back table, each row checked as the next is issued
    for (int i = 0; i <= N; i++) begin
      @(negedge clock);
      if (i > 0) begin
        r = ROWS[i - 1];
        v = pick(r.k[2:1]);
        chk({15'h0000, done}, 16'h0001);
        chk({15'h0000, v[16]}, {15'h0000, r.k[0]});
        if (r.k[0]) begin
          chk(v[15:0], r.e);
        end
        chk(flag_word & r.m, r.f);
      end
      if (i < N) begin
        put(ROWS[i].op, ROWS[i].k[3], ROWS[i].c, ROWS[i].d, ROWS[i].s, 16'h0000, 16'h0000);
      end else begin
        op_valid = 1'b0;
      end
    end
    $display("table test done");
    op1(high_byte_to_flags_op, 1'b0, 16'hff00, 16'h0000, 16'h0000, 16'h0000);
    chk(flag_word & 16'h00d5, 16'h00d5);
    keep = flag_word;
    op1(flags_to_high_byte_op, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk({8'h00, accumulator_out[15:8] & HIGH_BYTE_FLAG_MASK}, 16'h00d5);
    op1(high_byte_to_flags_op, 1'b0, 16'h2a00, 16'h0000, 16'h0000, 16'h0000);
    chk(flag_word, keep & 16'hff2a);
    keep = flag_word;
    op1(flag_push_op, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0100);
    chk(stack_pointer_out, 16'h00fe);
    chk({14'h0000, stack_write, stack_pointer_write}, 16'h0003);
    chk(stack_write_data, keep);
    op1(high_byte_to_flags_op, 1'b0, 16'hff00, 16'h0000, 16'h0000, 16'h0000);
    op1(flag_pop_op, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h00fe);
    chk(flag_word, keep);
    chk(stack_pointer_out, 16'h0100);
    $display("flag transfer test done");
    op1(unsigned_quotient_op, 1'b1, 16'h0000, 16'h0000, 16'h0001, 16'h0000);
    chk({13'h0000, divide_fault, accumulator_write, extension_write}, 16'h0004);
    chk({8'h00, fault_type}, {8'h00, DIVIDE_FAULT_TYPE});
    op1(unsigned_quotient_op, 1'b1, 16'h0000, 16'h0010, 16'h0001, 16'h0000);
    chk(accumulator_out, 16'h1000);
    chk(extension_out, 16'h0000);
    $display("divide test done");
    end_sim();
  end
endmodule : testbench
